// *** hw/pcd_pkg.sv ***
// Purpose: Shared constants and types of the panel command decoder
// Assumes: One 100 MHz clock, synchronous active-high reset
// Notes:   Opcodes, reset values, field positions and lengths live here
package pcd_pkg;
	// Opcodes of the upper command set
	localparam logic [7:0] OPC_WAVE_FIRST = 8'h23;
	localparam logic [7:0] OPC_WAVE_LAST  = 8'h28;
	localparam logic [7:0] OPC_GATE_WAVE  = 8'h29;
	localparam logic [7:0] OPC_CLK_RATIO  = 8'h30;
	localparam logic [7:0] OPC_TEMP_READ  = 8'h40;
	localparam logic [7:0] OPC_SRC_SEL    = 8'h41;
	localparam logic [7:0] OPC_SNS_WRITE  = 8'h42;
	localparam logic [7:0] OPC_SNS_READ   = 8'h43;
	localparam logic [7:0] OPC_BORDER     = 8'h50;
	localparam logic [7:0] OPC_LOW_SUPPLY = 8'h51;
	localparam logic [7:0] OPC_NONOVERLAP = 8'h60;
	localparam logic [7:0] OPC_TIMING_RES = 8'h61;
	localparam logic [7:0] OPC_FLASH      = 8'h65;
	localparam logic [7:0] OPC_VERSION    = 8'h70;
	localparam logic [7:0] OPC_STATUS     = 8'h71;
	localparam logic [7:0] OPC_AUTOCAL    = 8'h80;
	localparam logic [7:0] OPC_VCOM_READ  = 8'h81;
	localparam logic [7:0] OPC_DC_LEVEL   = 8'h82;
	// Parameter lengths in bytes
	localparam int         LUT_GROUP_LEN   = 13;
	localparam int         GATE_GROUP_LEN  = 10;
	localparam int         LUT_REPEATS     = 20;
	localparam logic [8:0] COLOR_TABLE_LEN = 9'(LUT_GROUP_LEN * LUT_REPEATS);
	localparam logic [8:0] GATE_TABLE_LEN  = 9'(GATE_GROUP_LEN * LUT_REPEATS);
	localparam int         WAVE_TABLES     = 7;
	localparam logic [2:0] GATE_TABLE_ID   = 3'h6;
	localparam logic [8:0] ONE_BYTE_LEN    = 9'h001;
	localparam logic [8:0] SNS_WRITE_LEN   = 9'h003;
	localparam logic [8:0] TIMING_RES_LEN  = 9'h004;
	localparam logic [8:0] TWO_BYTE_READ   = 9'h002;
	// Values after reset
	localparam logic [7:0] RST_CLK_RATIO   = 8'h3c;
	localparam logic [7:0] RST_BORDER      = 8'hf7;
	localparam logic [7:0] RST_NONOVERLAP  = 8'h22;
	localparam logic [6:0] RST_DC_LEVEL    = 7'h02;
	localparam logic [5:0] RST_STATUS      = 6'h02;
	localparam logic       RST_LOW_SUPPLY  = 1'b1;
	localparam logic [5:0] RST_AUTOCAL     = 6'h10;
	localparam logic [4:0] RST_PINS        = 5'h02;
	// Field positions and masks
	localparam int         SRC_SEL_BIT     = 7;
	localparam logic [7:0] CLK_RATIO_MASK  = 8'h3f;
	// Serial framing: pin order in the synchroniser and bits per transfer
	localparam int         PIN_SCLK = 0;
	localparam int         PIN_CSN  = 1;
	localparam int         PIN_DC   = 2;
	localparam int         PIN_SDI  = 3;
	localparam int         PIN_SEL  = 4;
	localparam logic [3:0] BITS_4LINE = 4'h8;
	localparam logic [3:0] BITS_3LINE = 4'h9;

	typedef enum logic [1:0] {st_idle, st_write, st_read} pcd_state_t;

	typedef struct packed {
		logic [4:0] q1, q2, q3, flt;
		logic       sclk_d;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic       vld;
		logic       isd;
		logic [7:0] dat;
		logic       sdo;
		logic       oe;
	} pcd_rx_t;

	typedef struct packed {
		pcd_state_t  st;
		logic [7:0]  opc;
		logic [8:0]  idx;
		logic [7:0]  clk_ratio;
		logic        src_sel;
		logic [7:0]  sw_attr, sw_hi, sw_lo;
		logic        sw_go;
		logic [7:0]  border;
		logic [7:0]  nonoverlap;
		logic [31:0] timing_resolution;
		logic        flash_en;
		logic [5:0]  version;
		logic [5:0]  autocal;
		logic [6:0]  dc_level;
		logic [10:0] temp;
		logic [15:0] srd;
		logic        low_sup;
		logic [5:0]  flags;
		logic [6:0]  vcom;
		logic        wv_we;
		logic [2:0]  wv_tab;
		logic [8:0]  wv_idx;
		logic [7:0]  wv_data;
	} pcd_core_t;
endpackage

// *** hw/pcd_byte_if.sv ***
// Purpose: Byte stream between the serial front end and the decoder core
// Assumes: All signals on clk
// Notes:   vld is a one-cycle pulse per completed transfer
`timescale 1ns/1ps
`default_nettype none
interface pcd_byte_if;
	logic       vld;
	logic       is_data;
	logic [7:0] data;
	logic       rd_active;
	logic [7:0] tx_byte;
	modport rx   (output vld, is_data, data, input rd_active, tx_byte);
	modport core (input vld, is_data, data, output rd_active, tx_byte);
endinterface
`default_nettype wire

// *** hw/pcd_serial_rx.sv ***
// Purpose: Serial front end, 3-line or 4-line, bytes in and read bytes out
// Assumes: Serial clock half period well above four clk cycles
// Notes:   Pins pass three flops; a level counts once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pcd_serial_rx
	import pcd_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Pins, ordered as in pcd_pkg pin indices
	input  wire logic [4:0] pins,
	// Read data pin drive
	output var  logic sda_o,
	output var  logic sda_oe,
	// Byte stream
	pcd_byte_if.rx    bus
);
	pcd_rx_t    r, n;
	logic       rise;
	logic [3:0] nbits, off, pos;

	// Synchronise, frame bits and steer the read driver
	always_comb begin
		n = r;
		n.vld = 1'b0;
		n.q1 = pins;
		n.q2 = r.q1;
		n.q3 = r.q2;
		n.flt = (~(r.q2 ^ r.q3) & r.q2) | ((r.q2 ^ r.q3) & r.flt);
		n.sclk_d = r.flt[PIN_SCLK];
		rise = r.flt[PIN_SCLK] & ~r.sclk_d;
		nbits = r.flt[PIN_SEL] ? BITS_3LINE : BITS_4LINE;
		off = nbits - BITS_4LINE;
		pos = r.cnt - off;
		if (r.flt[PIN_CSN]) begin
			n.cnt = 4'h0;
		end else if (rise) begin
			n.sh = {r.sh[6:0], r.flt[PIN_SDI]};
			if (r.cnt == nbits - 4'h1) begin
				n.cnt = 4'h0;
				n.vld = 1'b1;
				n.dat = {r.sh[6:0], r.flt[PIN_SDI]};
				// In-band flag is the first of nine bits
				n.isd = r.flt[PIN_SEL] ? r.sh[7] : r.flt[PIN_DC];
			end else begin
				n.cnt = r.cnt + 4'h1;
			end
		end
		// Device drives data bits only of a read transfer
		n.oe = bus.rd_active & ~r.flt[PIN_CSN] & (r.cnt >= off);
		n.sdo = bus.tx_byte[3'(4'h7 - pos)];
		if (rst) begin
			n = '0;
			n.q1 = RST_PINS;
			n.q2 = RST_PINS;
			n.q3 = RST_PINS;
			n.flt = RST_PINS;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		r <= n;
	end

	assign bus.vld = r.vld;
	assign bus.is_data = r.isd;
	assign bus.data = r.dat;
	assign sda_o = r.sdo;
	assign sda_oe = r.oe;

	frame_len_a: assert property (@(posedge clk) disable iff (rst)
		r.vld |-> $past(r.cnt, 2) == (r.flt[PIN_SEL] ? 4'h8 : 4'h7))
		else $error("transfer length does not match interface select");
endmodule // pcd_serial_rx
`default_nettype wire

// *** hw/pcd_wave_store.sv ***
// Purpose: Flop storage for the seven waveform tables
// Assumes: One write and one registered read per cycle
// Notes:   Tables are laid out at a stride of LEN bytes
`timescale 1ns/1ps
`default_nettype none
module pcd_wave_store #(
	parameter int TABLES = 7,
	parameter int LEN    = 260
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Write port
	input  wire logic       we,
	input  wire logic [2:0] wtab,
	input  wire logic [8:0] widx,
	input  wire logic [7:0] wdata,
	// Read port
	input  wire logic [2:0] rtab,
	input  wire logic [8:0] ridx,
	output var  logic [7:0] rdata
);
	localparam int AW = $clog2(TABLES * LEN);
	typedef struct packed {
		logic [TABLES*LEN-1:0][7:0] mem;
		logic [7:0]                 rd;
	} pcd_wave_t;
	pcd_wave_t     r, n;
	logic [AW-1:0] wa, ra;

	// Flat index from table and byte position
	always_comb begin
		wa = AW'(wtab) * AW'(LEN) + AW'(widx);
		ra = AW'(rtab) * AW'(LEN) + AW'(ridx);
		n = r;
		if (we) begin
			n.mem[wa] = wdata;
		end
		n.rd = r.mem[ra];
		if (rst) begin
			n = '0;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		r <= n;
	end

	assign rdata = r.rd;
endmodule // pcd_wave_store
`default_nettype wire

// *** hw/pcd_top.sv ***
// Purpose: Decoder for opcodes 23h to 82h of the panel controller
// Assumes: Status and sensor inputs come from logic on clk
// Notes:   A new opcode always aborts the previous parameter sequence
`timescale 1ns/1ps
`default_nettype none
module pcd_top
	import pcd_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Serial pins
	input  wire logic        sclk,
	input  wire logic        csn_pin,
	input  wire logic        dc_pin,
	input  wire logic        sda_i,
	output var  logic        sda_o,
	output var  logic        sda_oe,
	input  wire logic        interface_select_pin,
	// Values reported back to the host
	input  wire logic [10:0] temp_in,
	input  wire logic        temp_vld,
	input  wire logic [15:0] sensor_rd_in,
	input  wire logic        sensor_rd_vld,
	input  wire logic        low_supply_in,
	input  wire logic        low_supply_vld,
	input  wire logic [5:0]  status_in,
	input  wire logic [6:0]  vcom_in,
	input  wire logic        vcom_vld,
	// Clock synthesis and sensor control
	output var  logic [7:0]  clk_ratio,
	output var  logic        sensor_source_select,
	output var  logic [7:0]  sensor_write_attribute,
	output var  logic [7:0]  sensor_write_high,
	output var  logic [7:0]  sensor_write_low,
	output var  logic        sensor_write_go,
	// Panel timing
	output var  logic [2:0]  border_level,
	output var  logic        data_polarity,
	output var  logic [3:0]  data_interval,
	output var  logic [3:0]  source_to_gate_gap,
	output var  logic [3:0]  gate_to_source_gap,
	output var  logic [9:0]  horizontal_size,
	output var  logic [8:0]  vertical_size,
	// Flash, version and common electrode
	output var  logic        flash_access_en,
	output var  logic        maker_select_bit,
	output var  logic        shrink_bit,
	output var  logic [3:0]  wave_table_version,
	output var  logic [5:0]  autocal_cfg,
	output var  logic [6:0]  common_dc_level,
	// Wave table read port
	input  wire logic [2:0]  wave_rd_tab,
	input  wire logic [8:0]  wave_rd_idx,
	output var  logic [7:0]  wave_rd_data
);
	pcd_core_t r, n;
	pcd_byte_if bi ();

	// Parameter bytes that a write opcode takes, zero if none
	function automatic logic [8:0] wr_len(input logic [7:0] opc);
		logic [8:0] len;
		len = 9'h000;
		if (opc >= OPC_WAVE_FIRST && opc <= OPC_WAVE_LAST) begin
			len = COLOR_TABLE_LEN;
		end
		case (opc)
			OPC_GATE_WAVE:  len = GATE_TABLE_LEN;
			OPC_SNS_WRITE:  len = SNS_WRITE_LEN;
			OPC_TIMING_RES: len = TIMING_RES_LEN;
			OPC_CLK_RATIO, OPC_SRC_SEL, OPC_BORDER, OPC_NONOVERLAP,
			OPC_FLASH, OPC_VERSION, OPC_AUTOCAL, OPC_DC_LEVEL: begin
				len = ONE_BYTE_LEN;
			end
			default: ;
		endcase
		return len;
	endfunction

	// Bytes that a read opcode returns, zero if none
	function automatic logic [8:0] rd_len(input logic [7:0] opc);
		case (opc)
			OPC_TEMP_READ, OPC_SNS_READ: return TWO_BYTE_READ;
			OPC_LOW_SUPPLY, OPC_STATUS, OPC_VCOM_READ: return ONE_BYTE_LEN;
			default: return 9'h000;
		endcase
	endfunction

	// Serial front end
	pcd_serial_rx u_rx (
		.clk    (clk),
		.rst    (rst),
		.pins   ({interface_select_pin, sda_i, dc_pin, csn_pin, sclk}),
		.sda_o  (sda_o),
		.sda_oe (sda_oe),
		.bus    (bi)
	);

	// Wave table storage
	pcd_wave_store #(
		.TABLES (WAVE_TABLES),
		.LEN    (int'(COLOR_TABLE_LEN))
	) u_wave (
		.clk   (clk),
		.rst   (rst),
		.we    (r.wv_we),
		.wtab  (r.wv_tab),
		.widx  (r.wv_idx),
		.wdata (r.wv_data),
		.rtab  (wave_rd_tab),
		.ridx  (wave_rd_idx),
		.rdata (wave_rd_data)
	);

	// Read byte for the current opcode and position
	always_comb begin
		bi.rd_active = (r.st == st_read);
		bi.tx_byte = 8'h00;
		case (r.opc)
			OPC_TEMP_READ: begin
				bi.tx_byte = (r.idx == 9'h000) ? r.temp[10:3]
					: {r.temp[2:0], 5'h00};
			end
			OPC_SNS_READ: begin
				bi.tx_byte = (r.idx == 9'h000) ? r.srd[15:8]
					: r.srd[7:0];
			end
			OPC_LOW_SUPPLY: bi.tx_byte = {7'h00, r.low_sup};
			OPC_STATUS:     bi.tx_byte = {2'h0, r.flags};
			OPC_VCOM_READ:  bi.tx_byte = {1'b0, r.vcom};
			default: ;
		endcase
	end

	// Decoder state, parameter storage and reported values
	always_comb begin
		n = r;
		n.sw_go = 1'b0;
		n.wv_we = 1'b0;
		if (temp_vld) begin
			n.temp = temp_in;
		end
		if (sensor_rd_vld) begin
			n.srd = sensor_rd_in;
		end
		if (low_supply_vld) begin
			n.low_sup = low_supply_in;
		end
		if (vcom_vld) begin
			n.vcom = vcom_in;
		end
		n.flags = status_in;
		if (bi.vld && !bi.is_data) begin
			// Opcode byte restarts the sequence
			n.opc = bi.data;
			n.idx = 9'h000;
			if (rd_len(bi.data) != 9'h000) begin
				n.st = st_read;
			end else if (wr_len(bi.data) != 9'h000) begin
				n.st = st_write;
			end else begin
				n.st = st_idle;
			end
		end else if (bi.vld) begin
			case (r.st)
				st_write: begin
					n.idx = r.idx + 9'h001;
					if (r.idx == wr_len(r.opc) - 9'h001) begin
						n.st = st_idle;
					end
					if (r.opc >= OPC_WAVE_FIRST &&
						r.opc <= OPC_WAVE_LAST) begin
						n.wv_we = 1'b1;
						n.wv_tab = 3'(r.opc - OPC_WAVE_FIRST);
						n.wv_idx = r.idx;
						n.wv_data = bi.data;
					end
					case (r.opc)
						OPC_GATE_WAVE: begin
							n.wv_we = 1'b1;
							n.wv_tab = GATE_TABLE_ID;
							n.wv_idx = r.idx;
							n.wv_data = bi.data;
						end
						OPC_CLK_RATIO: begin
							n.clk_ratio = bi.data & CLK_RATIO_MASK;
						end
						OPC_SRC_SEL: begin
							n.src_sel = bi.data[SRC_SEL_BIT];
						end
						OPC_SNS_WRITE: begin
							case (r.idx[1:0])
								2'h0: n.sw_attr = bi.data;
								2'h1: n.sw_hi = bi.data;
								default: begin
									n.sw_lo = bi.data;
									n.sw_go = 1'b1;
								end
							endcase
						end
						OPC_BORDER:     n.border = bi.data;
						OPC_NONOVERLAP: n.nonoverlap = bi.data;
						OPC_TIMING_RES: n.timing_resolution = {r.timing_resolution[23:0], bi.data};
						OPC_FLASH:      n.flash_en = bi.data[0];
						OPC_VERSION:    n.version = bi.data[5:0];
						OPC_AUTOCAL:    n.autocal = bi.data[5:0];
						OPC_DC_LEVEL:   n.dc_level = bi.data[6:0];
						default: ;
					endcase
				end
				st_read: begin
					// Host clocked one read byte out
					n.idx = r.idx + 9'h001;
					if (r.idx == rd_len(r.opc) - 9'h001) begin
						n.st = st_idle;
					end
				end
				default: ;
			endcase
		end
		if (rst) begin
			n = '0;
			n.st = st_idle;
			n.clk_ratio = RST_CLK_RATIO;
			n.border = RST_BORDER;
			n.nonoverlap = RST_NONOVERLAP;
			n.dc_level = RST_DC_LEVEL;
			n.flags = RST_STATUS;
			n.low_sup = RST_LOW_SUPPLY;
			n.autocal = RST_AUTOCAL;
		end
	end

	// State register
	always_ff @(posedge clk) begin
		r <= n;
	end

	// Outputs are slices of the state register
	assign clk_ratio = r.clk_ratio;
	assign sensor_source_select = r.src_sel;
	assign sensor_write_attribute = r.sw_attr;
	assign sensor_write_high = r.sw_hi;
	assign sensor_write_low = r.sw_lo;
	assign sensor_write_go = r.sw_go;
	assign border_level = r.border[7:5];
	assign data_polarity = r.border[4];
	assign data_interval = r.border[3:0];
	assign source_to_gate_gap = r.nonoverlap[7:4];
	assign gate_to_source_gap = r.nonoverlap[3:0];
	assign horizontal_size = {r.timing_resolution[17:16], r.timing_resolution[31:24]};
	assign vertical_size = {r.timing_resolution[8], r.timing_resolution[7:0]};
	assign flash_access_en = r.flash_en;
	assign maker_select_bit = r.version[5];
	assign shrink_bit = r.version[4];
	assign wave_table_version = r.version[3:0];
	assign autocal_cfg = r.autocal;
	assign common_dc_level = r.dc_level;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence wr_byte(logic [7:0] op);
		bi.vld && bi.is_data && r.st == st_write && r.opc == op;
	endsequence

	// Parameter byte of a given opcode at a given position
	sequence wr_at(logic [7:0] op, logic [8:0] i);
		bi.vld && bi.is_data && r.st == st_write && r.opc == op &&
		r.idx == i;
	endsequence

	reset_defaults_a: assert property (
		$past(rst) |-> clk_ratio == 8'h3c && r.border == 8'hf7 &&
		r.nonoverlap == 8'h22 && common_dc_level == 7'h02 &&
		r.flags == 6'h02 && r.low_sup && !flash_access_en)
		else $error("register values wrong after reset");
	ratio_write_a: assert property (
		wr_byte(OPC_CLK_RATIO) |=> clk_ratio == {2'b00, $past(bi.data[5:0])})
		else $error("clock ratio byte not stored");
	temp_low_a: assert property (
		r.st == st_read && r.opc == OPC_TEMP_READ && r.idx == 9'h001
		|-> bi.tx_byte == {r.temp[2:0], 5'h00})
		else $error("second temperature byte wrong");
	src_sel_a: assert property (
		wr_byte(OPC_SRC_SEL) |=> sensor_source_select == $past(bi.data[7]))
		else $error("sensor source bit not stored");
	sensor_go_a: assert property (
		wr_at(OPC_SNS_WRITE, 9'h002) |=> sensor_write_go &&
		sensor_write_low == $past(bi.data) ##1 !sensor_write_go)
		else $error("sensor write not issued once");
	supply_read_a: assert property (
		r.st == st_read && r.opc == OPC_LOW_SUPPLY
		|-> bi.tx_byte == {7'h00, r.low_sup} && bi.rd_active)
		else $error("low supply byte wrong");
	flash_en_a: assert property (
		wr_byte(OPC_FLASH) |=> flash_access_en == $past(bi.data[0]))
		else $error("flash access bit not stored");
	status_read_a: assert property (
		r.st == st_read && r.opc == OPC_STATUS
		|-> bi.tx_byte[7:6] == 2'b00 &&
		bi.tx_byte[5:0] == $past(status_in))
		else $error("status byte wrong");
	opcode_start_a: assert property (
		bi.vld && !bi.is_data |=> r.idx == 9'h000 && r.opc == $past(bi.data))
		else $error("opcode did not restart the sequence");
	idle_ignore_a: assert property (
		r.st == st_idle && bi.vld && bi.is_data
		|=> $stable(clk_ratio) && $stable(r.border) && !r.wv_we)
		else $error("stray parameter byte was stored");
	wave_end_a: assert property (
		bi.vld && bi.is_data && r.st == st_write && r.idx == 9'h103 &&
		r.opc >= OPC_WAVE_FIRST && r.opc <= OPC_WAVE_LAST
		|=> r.st == st_idle && r.wv_we && r.wv_idx == 9'h103)
		else $error("colour table length wrong");
	gate_end_a: assert property (
		wr_at(OPC_GATE_WAVE, 9'h0c7)
		|=> r.st == st_idle && r.wv_tab == 3'h6 && r.wv_we)
		else $error("gate table length wrong");

	read_done_c: cover property (r.st == st_read ##[1:1000] r.st == st_idle);
	sensor_go_c: cover property (sensor_write_go);
	wave_full_c: cover property (wr_at(OPC_WAVE_LAST, 9'h103));
endmodule // pcd_top
`default_nettype wire

// *** dv/pcd_host_model.sv ***
// Purpose: Host side of the serial command bus
// Assumes: HALF clk cycles per serial clock phase
// Notes:   Serial clock stands still low outside frames
`timescale 1ns/1ps
`default_nettype none
module pcd_host_model #(
	parameter int HALF = 6
) (
	// Clock and mode
	input  wire logic clk,
	input  wire logic sel,
	// Serial pins
	output var  logic sclk,
	output var  logic csn_pin,
	output var  logic dc_pin,
	output var  logic sda_i,
	input  wire logic sda_o,
	input  wire logic sda_oe
);
	logic host_d;
	logic host_oe;

	// Idle pin levels
	initial begin
		sclk = 1'b0;
		csn_pin = 1'b1;
		dc_pin = 1'b0;
		host_d = 1'b0;
		host_oe = 1'b1;
	end

	// Shared data line; a released line shows the inverse of its last bit
	always_comb begin
		if (sda_oe)
			sda_i = sda_o;
		else if (host_oe)
			sda_i = host_d;
		else
			sda_i = ~host_d;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// One bit: data set while low, taken at the rise
	task automatic bit_out(input logic b);
		host_d = b;
		wait_clk(HALF);
		sclk = 1'b1;
		wait_clk(HALF);
		sclk = 1'b0;
	endtask

	task automatic frame_on();
		csn_pin = 1'b0;
		wait_clk(HALF);
	endtask

	task automatic frame_off();
		wait_clk(HALF);
		csn_pin = 1'b1;
		wait_clk(2 * HALF);
	endtask

	// Opcode with flag low, parameter with flag high, MSB first
	task automatic send(input logic dc, input logic [7:0] b);
		host_oe = 1'b1;
		dc_pin = dc;
		if (sel)
			bit_out(dc);
		for (int i = 7; i >= 0; i--)
			bit_out(b[i]);
	endtask

	// Read byte: host releases the line, device drives it
	task automatic recv(output logic [7:0] b);
		dc_pin = 1'b1;
		if (sel)
			bit_out(1'b1);
		host_oe = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			wait_clk(HALF);
			b[i] = sda_i;
			sclk = 1'b1;
			wait_clk(HALF);
			sclk = 1'b0;
		end
	endtask
endmodule // pcd_host_model
`default_nettype wire

// *** dv/panel_command_decoder_tb.sv ***
// Purpose: Self-checking bench of the panel command decoder
// Assumes: Host model at six clk per serial phase
// Notes:   Only tables 28h and 29h are filled whole, to keep the run short
`timescale 1ns/1ps
`default_nettype none
module panel_command_decoder_tb;
	import pcd_pkg::*;
	typedef struct packed {
		logic [7:0] ratio;
		logic       src;
		logic [7:0] border_and_interval;
		logic [7:0] nonoverlap_timing;
		logic       flash;
		logic [5:0] ver;
		logic [5:0] acal;
		logic [6:0] dc;
	} pcd_cfg_t;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        sel = 1'b0;
	logic        sclk, csn_pin, dc_pin, sda_i, sda_o, sda_oe;
	logic [10:0] temp_in = '0;
	logic [15:0] srd_in = '0;
	logic [6:0]  vcom_in = '0;
	logic [5:0]  status_in = 6'h02;
	logic        pulse = 1'b0;
	logic        low_in = 1'b1;
	logic [2:0]  rtab = '0;
	logic [8:0]  ridx = '0;
	logic [7:0]  rdata, w_attr, w_high, w_low, clk_ratio;
	logic [6:0]  dcl;
	logic [5:0]  acal;
	logic [3:0]  iv, s2g, g2s, ver;
	logic [2:0]  bl;
	logic        go, src, pol, fl, mk, sh;
	logic [9:0]  hs;
	logic [8:0]  vs;
	pcd_cfg_t    e;
	int          n_errors = 0;
	int          n_checks = 0;
	int          n_go = 0;
	int          cycles = 0;
	wire [44:0]  cfg = {clk_ratio, src, bl, pol, iv, s2g, g2s, fl, mk, sh,
		ver, acal, dcl};

	// 100 MHz clock
	always #5 clk = ~clk;

	pcd_host_model #(.HALF(6)) host_u (.clk(clk), .sel(sel), .sclk(sclk),
		.csn_pin(csn_pin), .dc_pin(dc_pin), .sda_i(sda_i), .sda_o(sda_o),
		.sda_oe(sda_oe));

	pcd_top dut_u (.clk(clk), .rst(rst), .sclk(sclk), .csn_pin(csn_pin),
		.dc_pin(dc_pin), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
		.interface_select_pin(sel), .temp_in(temp_in), .temp_vld(pulse),
		.sensor_rd_in(srd_in), .sensor_rd_vld(pulse),
		.low_supply_in(low_in), .low_supply_vld(pulse),
		.status_in(status_in), .vcom_in(vcom_in), .vcom_vld(pulse),
		.clk_ratio(clk_ratio), .sensor_source_select(src),
		.sensor_write_attribute(w_attr), .sensor_write_high(w_high),
		.sensor_write_low(w_low), .sensor_write_go(go),
		.border_level(bl), .data_polarity(pol), .data_interval(iv),
		.source_to_gate_gap(s2g), .gate_to_source_gap(g2s),
		.horizontal_size(hs), .vertical_size(vs), .flash_access_en(fl),
		.maker_select_bit(mk), .shrink_bit(sh), .wave_table_version(ver),
		.autocal_cfg(acal), .common_dc_level(dcl), .wave_rd_tab(rtab),
		.wave_rd_idx(ridx), .wave_rd_data(rdata));

	// Cycle ceiling and write-pulse counter
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (go === 1'b1)
			n_go <= n_go + 1;
		if (cycles == 95000) begin
			n_errors++;
			final_report();
		end
	end

	task automatic final_report();
		if (n_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t byte got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmp_cfg();
		n_checks++;
		if (cfg !== e) begin
			n_errors++;
			$display("ERROR %0t config got %h exp %h", $time, cfg, e);
		end
	endtask

	task automatic cmp_size(input logic [18:0] got, input logic [18:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t size got %h exp %h", $time, got, exp);
		end
	endtask

	// One-parameter write; the expected field follows the written byte
	task automatic wr1(input logic [7:0] opc, input logic [7:0] d);
		host_u.frame_on();
		host_u.send(1'b0, opc);
		host_u.send(1'b1, d);
		host_u.frame_off();
		case (opc)
			OPC_CLK_RATIO: e.ratio = d & 8'h3f;
			OPC_SRC_SEL: e.src = d[7];
			OPC_BORDER: e.border_and_interval = d;
			OPC_NONOVERLAP: e.nonoverlap_timing = d;
			OPC_FLASH: e.flash = d[0];
			OPC_VERSION: e.ver = d[5:0];
			OPC_AUTOCAL: e.acal = d[5:0];
			OPC_DC_LEVEL: e.dc = d[6:0];
			default: ;
		endcase
		cmp_cfg();
	endtask

	// Read command of n bytes, compared with x (one byte sits on top)
	task automatic rchk(input logic [7:0] opc, input int n,
		input logic [15:0] x);
		logic [7:0] b;
		host_u.frame_on();
		host_u.send(1'b0, opc);
		host_u.recv(b);
		cmp_byte(b, x[15:8]);
		if (n == 2) begin
			host_u.recv(b);
			cmp_byte(b, x[7:0]);
		end
		host_u.frame_off();
	endtask

	task automatic wchk(input int t, input int i, input logic [7:0] x);
		rtab = 3'(t);
		ridx = 9'(i);
		step(2);
		cmp_byte(rdata, x);
	endtask

	task automatic t_defaults();
		cmp_cfg();
		rchk(OPC_TEMP_READ, 2, 16'h0000);
		rchk(OPC_SNS_READ, 2, 16'h0000);
		rchk(OPC_LOW_SUPPLY, 1, 16'h0100);
		rchk(OPC_STATUS, 1, 16'h0200);
		rchk(OPC_VCOM_READ, 1, 16'h0000);
	endtask

	// Every one-byte write opcode with all ones, then an alternating pattern
	task automatic t_config();
		logic [7:0] ops [8] = '{OPC_CLK_RATIO, OPC_SRC_SEL, OPC_BORDER,
			OPC_NONOVERLAP, OPC_FLASH, OPC_VERSION, OPC_AUTOCAL, OPC_DC_LEVEL};
		for (int p = 0; p < 2; p++)
			foreach (ops[i])
				wr1(ops[i], p ? 8'h5a : 8'hff);
		wr1(8'h90, 8'h12);
	endtask

	// Sensor write with one byte too many
	task automatic t_sensor();
		host_u.frame_on();
		host_u.send(1'b0, OPC_SNS_WRITE);
		host_u.send(1'b1, 8'ha1);
		host_u.send(1'b1, 8'hb2);
		host_u.send(1'b1, 8'hc3);
		host_u.send(1'b1, 8'hd4);
		host_u.frame_off();
		cmp_byte(w_attr, 8'ha1);
		cmp_byte(w_high, 8'hb2);
		cmp_byte(w_low, 8'hc3);
		cmp_byte(8'(n_go), 8'h01);
	endtask

	// Timing sizes: width over bytes 1-2, height over 3-4, unused bits set
	task automatic t_timing();
		host_u.frame_on();
		host_u.send(1'b0, OPC_TIMING_RES);
		host_u.send(1'b1, 8'h58);
		host_u.send(1'b1, 8'hfe);
		host_u.send(1'b1, 8'hff);
		host_u.send(1'b1, 8'hc0);
		host_u.frame_off();
		cmp_size({hs, vs}, {10'h258, 9'h1c0});
	endtask

	// Latch new report values, then read each back
	task automatic t_reads();
		temp_in = 11'h5a3;
		srd_in = 16'hbeef;
		vcom_in = 7'h55;
		low_in = 1'b0;
		status_in = 6'h2d;
		pulse = 1'b1;
		step(1);
		pulse = 1'b0;
		temp_in = 11'h000;
		rchk(OPC_TEMP_READ, 2, 16'hb460);
		rchk(OPC_SNS_READ, 2, 16'hbeef);
		rchk(OPC_LOW_SUPPLY, 1, 16'h0000);
		rchk(OPC_STATUS, 1, 16'h2d00);
		rchk(OPC_VCOM_READ, 1, 16'h5500);
	endtask

	task automatic t_three_line();
		sel = 1'b1;
		step(4);
		wr1(OPC_DC_LEVEL, 8'h33);
		rchk(OPC_STATUS, 1, 16'h2d00);
		sel = 1'b0;
		step(4);
		wr1(OPC_CLK_RATIO, 8'hc5);
	endtask

	// Short loads of 23h-27h, full 28h and 29h, each with a spare byte
	task automatic t_tables();
		for (int t = 0; t < 7; t++) begin
			host_u.frame_on();
			host_u.send(1'b0, OPC_WAVE_FIRST + 8'(t));
			for (int k = 0; k < (t < 5 ? 2 : t == 5 ? 261 : 201); k++)
				host_u.send(1'b1, 8'(k + t));
			host_u.frame_off();
		end
		for (int t = 0; t < 5; t++) begin
			wchk(t, 1, 8'(1 + t));
			wchk(t, 2, 8'h00);
		end
		wchk(5, 0, 8'h05);
		wchk(5, 259, 8'(259 + 5));
		wchk(6, 199, 8'(199 + 6));
		wchk(6, 200, 8'h00);
	endtask

	// Main sequence
	initial begin
		step(10);
		rst = 1'b0;
		step(5);
		e = '{8'h3c, 1'b0, 8'hf7, 8'h22, 1'b0, 6'h00, 6'h10, 7'h02};
		t_defaults();
		t_config();
		t_sensor();
		t_timing();
		t_reads();
		t_three_line();
		t_tables();
		final_report();
	end
endmodule // panel_command_decoder_tb
`default_nettype wire
